// file: core/aio_event_defs.vh
`ifndef AIO_EVENT_DEFS_VH
`define AIO_EVENT_DEFS_VH

// ********************************************
// register offsets (byte addresses, word aligned)
// ********************************************
`define OFF_CTRL        8'h00
`define OFF_HI_LIM0     8'h04
`define OFF_LO_LIM0     8'h08
`define OFF_HI_LIM2     8'h0C
`define OFF_LO_LIM2     8'h10
`define OFF_INFO        8'h14
`define OFF_DIAG0       8'h18
`define OFF_CHAN_DIAG   8'h1C
`define OFF_IRQ_STAT    8'h20
`define OFF_IRQ_MASK    8'h24
`define OFF_ACK         8'h28
`define OFF_VALUE_BASE  8'h40

// ********************************************
// control register fields
// ********************************************
`define CTRL_LIM_EN0    0
`define CTRL_LIM_EN2    1
`define CTRL_DIAG_EN    2
`define CTRL_WB_EN      3
`define CTRL_RESET      32'h0000_0000

// ********************************************
// irq status bits
// ********************************************
`define IRQ_LIMIT       0
`define IRQ_DIAG        1
`define IRQ_LOST        2

// ********************************************
// diagnostic record layout
// ********************************************
`define DREC_BYTE1      8'h15
`define DREC_LOST_BIT   30
`define DREC_SUPPLY_BIT 4
`define DREC_PARAM_BIT  7
`define DREC_CHAN_BIT   3
`define DREC_MOD_BIT    0

// per channel diagnostic byte positions
`define CD_PARAM        0
`define CD_CMODE        1
`define CD_WBREAK       4
`define CD_UNDER        6
`define CD_OVER         7

// ********************************************
// measured value substitutes and thresholds
// ********************************************
`define VAL_OVERFLOW    16'h7FFF
`define VAL_UNDERFLOW   16'h8000
`define WB_UA           3600
`define CMODE_MV        3000
`define DEF_UPPER_OVR   16'h7EFF
`define DEF_LOWER_UND   16'h8100
`define FCODE_MAX       8'h1F

`endif

// file: core/limit_cmp.v
`timescale 1ns/1ps
`default_nettype none
// window compare of one limit-monitored channel, registered outputs
module limit_cmp (
    input wire core_clk, // clock
    input wire nrst, // async reset, active low
    input wire signed [15:0] value, // converted value
    input wire signed [15:0] hi_lim, // high limit
    input wire signed [15:0] lo_lim, // low limit
    output reg above_reg, // value above high limit
    output reg below_reg // value below low limit
);
    // registered compare so the caller sees a clean edge
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            above_reg <= 1'b0;
            below_reg <= 1'b0;
        end else begin
            above_reg <= (value > hi_lim);
            below_reg <= (value < lo_lim);
        end
    end
endmodule // limit_cmp
`default_nettype wire

// file: core/value_mem.v
`timescale 1ns/1ps
`default_nettype none
// small memory for eight measured values, registered read port
module value_mem (
    input wire core_clk, // clock
    input wire [2:0] wr_addr, // write channel
    input wire wr_en, // write strobe
    input wire [15:0] wr_data, // value to store
    input wire [2:0] rd_addr, // read channel
    output reg [15:0] rd_data // registered read data
);
    reg [15:0] mem [0:7];
    // memory has no reset; values are only read after a conversion wrote them
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // value_mem
`default_nettype wire

// file: core/aio_event_top.v
`timescale 1ns/1ps
`default_nettype none
`include "aio_event_defs.vh"
// Behaviour
// - in 4 to 20 mA range, loop current under 3.6 mA flags wire break
// - run time parameter record with bad function code flags parameter error
// - value below the underdrive region flags underflow
// - value above the overdrive region flags overflow
// - ground potential difference above 3 V or broken ground flags common mode
// - missing or failed external load supply raises a diagnostic condition
// - limit interrupt only when enabled and value outside the limit window
// - each monitored channel has configurable high and low limits
// - only channels 0 and 2 have limit monitoring
// - limit interrupts are disabled after reset until software enables them
// - info byte 0: bit 0 channel 0 above, bit 1 channel 2 above
// - info byte 1: bit 0 channel 0 below, bit 1 channel 2; bytes 2,3 zero
// - same cause recurring while previous is serviced counts as lost interrupt
// - lost interrupt raises diagnostic and sets bit 6 of record byte 3
// - diagnostic interrupt forwarded only when enabled
// - overflow stores 7FFF, underflow stores 8000, regardless of settings
module aio_event_top (
    input wire core_clk, // 20 MHz clock
    input wire nrst, // async reset, active low
    input wire [7:0] addr, // register byte address
    input wire [31:0] wdata, // write data
    input wire wr, // write strobe
    input wire rd, // read strobe
    output reg [31:0] rdata_reg, // read data, cycle after rd
    input wire conv_valid, // one-cycle pulse: new conversion
    input wire [2:0] conv_chan, // channel of conversion
    input wire [15:0] conv_value, // raw converted value
    input wire [15:0] loop_ua, // loop current in microamps
    input wire cur_4_20, // channel in 4..20 mA range
    input wire [15:0] gnd_diff_mv, // ground potential difference, mV
    input wire gnd_open, // ground connection broken
    input wire ext_supply_ok, // external load supply present
    input wire param_wr, // pulse: run time parameter record written
    input wire [2:0] param_chan, // channel of the record
    input wire [7:0] param_fcode, // function code of the record
    output reg limit_irq_reg, // limit interrupt request level
    output reg diag_irq_reg, // diagnostic interrupt request level
    output reg irq_reg // masked summary interrupt
);
    // ********************************************
    // decoding helpers
    // ********************************************
    function [15:0] subst;
        input [15:0] v;
        input ov;
        input un;
        begin
            subst = ov ? `VAL_OVERFLOW : (un ? `VAL_UNDERFLOW : v);
        end
    endfunction

    function is_addr;
        input [7:0] a;
        input [7:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    // ********************************************
    // registers
    // ********************************************
    reg [31:0] ctrl_reg;
    reg [15:0] hi0_reg, lo0_reg, hi2_reg, lo2_reg;
    reg [15:0] v0_reg, v2_reg;
    reg [31:0] info_reg;
    reg busy_reg;
    reg lost_reg;
    reg supply_err_reg;
    reg [7:0] chd_reg [0:7];
    reg [2:0] stat_reg;
    reg [2:0] mask_reg;
    reg rd_val_reg;
    reg [31:0] rd_mux_reg;

    wire ov = ($signed(conv_value) > $signed(`DEF_UPPER_OVR));
    wire un = ($signed(conv_value) < $signed(`DEF_LOWER_UND));
    wire wb = cur_4_20 && ctrl_reg[`CTRL_WB_EN] && (loop_ua < `WB_UA);
    wire cm = (gnd_diff_mv > `CMODE_MV) || gnd_open;
    wire bad_fc = param_wr && (param_fcode > `FCODE_MAX);
    wire [15:0] val_out = subst(conv_value, ov, un);

    wire a0, b0, a2, b2;
    wire wr_ack = wr && is_addr(addr, `OFF_ACK);

    // ********************************************
    // limit compare for the two monitored channels
    // ********************************************
    limit_cmp cmp0 (
        .core_clk(core_clk),
        .nrst(nrst),
        .value(v0_reg),
        .hi_lim(hi0_reg),
        .lo_lim(lo0_reg),
        .above_reg(a0),
        .below_reg(b0)
    );
    limit_cmp cmp2 (
        .core_clk(core_clk),
        .nrst(nrst),
        .value(v2_reg),
        .hi_lim(hi2_reg),
        .lo_lim(lo2_reg),
        .above_reg(a2),
        .below_reg(b2)
    );

    // ********************************************
    // stored measured values per channel
    // ********************************************
    wire [15:0] mem_rd;
    value_mem vmem (
        .core_clk(core_clk),
        .wr_addr(conv_chan),
        .wr_en(conv_valid),
        .wr_data(val_out),
        .rd_addr(addr[4:2]),
        .rd_data(mem_rd)
    );

    // new limit causes; a channel only counts when its enable bit is set
    wire [3:0] cause = {b2 & ctrl_reg[`CTRL_LIM_EN2], b0 & ctrl_reg[`CTRL_LIM_EN0],
                        a2 & ctrl_reg[`CTRL_LIM_EN2], a0 & ctrl_reg[`CTRL_LIM_EN0]};
    wire [3:0] held = {info_reg[9:8], info_reg[1:0]};
    reg [3:0] cause_d_reg;
    wire [3:0] rise = cause & ~cause_d_reg;
    // edge based so a value that stays outside does not re-raise the flag right after ack
    wire [3:0] fresh = rise & ~held;
    wire [3:0] again = cause & held;

    // ********************************************
    // configuration registers
    // ********************************************
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `CTRL_RESET;
            hi0_reg <= 16'h0000;
            lo0_reg <= 16'h0000;
            hi2_reg <= 16'h0000;
            lo2_reg <= 16'h0000;
            mask_reg <= 3'h0;
        end else if (wr) begin
            if (is_addr(addr, `OFF_CTRL)) ctrl_reg <= {28'h0000000, wdata[3:0]};
            if (is_addr(addr, `OFF_HI_LIM0)) hi0_reg <= wdata[15:0];
            if (is_addr(addr, `OFF_LO_LIM0)) lo0_reg <= wdata[15:0];
            if (is_addr(addr, `OFF_HI_LIM2)) hi2_reg <= wdata[15:0];
            if (is_addr(addr, `OFF_LO_LIM2)) lo2_reg <= wdata[15:0];
            if (is_addr(addr, `OFF_IRQ_MASK)) mask_reg <= wdata[2:0];
        end
    end

    // ********************************************
    // channel values for the limit compare
    // ********************************************
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            v0_reg <= 16'h0000;
            v2_reg <= 16'h0000;
            cause_d_reg <= 4'h0;
        end else begin
            if (conv_valid && conv_chan == 3'h0) v0_reg <= val_out;
            if (conv_valid && conv_chan == 3'h2) v2_reg <= val_out;
            cause_d_reg <= cause;
        end
    end

    // ********************************************
    // interrupt information word and service tracking
    // ********************************************
    // a cause that rises again while its flag still stands is a lost interrupt;
    // a fresh cause in the ack cycle survives because set beats clear
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            info_reg <= 32'h0000_0000;
            busy_reg <= 1'b0;
            lost_reg <= 1'b0;
        end else begin
            info_reg[1:0] <= (wr_ack ? 2'b00 : info_reg[1:0]) | fresh[1:0];
            info_reg[9:8] <= (wr_ack ? 2'b00 : info_reg[9:8]) | fresh[3:2];
            info_reg[7:2] <= 6'h00;
            info_reg[31:10] <= 22'h000000;
            busy_reg <= (busy_reg && !wr_ack) || (|fresh);
            if (busy_reg && |(rise & again)) lost_reg <= 1'b1;
            else if (wr && is_addr(addr, `OFF_DIAG0) && wdata[`DREC_LOST_BIT]) lost_reg <= 1'b0;
        end
    end

    // ********************************************
    // per channel diagnostics and supply
    // ********************************************
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : chd
            always @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    chd_reg[g] <= 8'h00;
                end else if (conv_valid && conv_chan == g) begin
                    chd_reg[g] <= {ov, un, 1'b0, wb, 2'b00, cm,
                                   chd_reg[g][`CD_PARAM] | (bad_fc && param_chan == g)};
                end else if (bad_fc && param_chan == g) begin
                    chd_reg[g][`CD_PARAM] <= 1'b1;
                end else if (param_wr && param_chan == g) begin
                    chd_reg[g][`CD_PARAM] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) supply_err_reg <= 1'b0;
        else supply_err_reg <= !ext_supply_ok;
    end

    wire any_chan = |{chd_reg[0], chd_reg[1], chd_reg[2], chd_reg[3],
                      chd_reg[4], chd_reg[5], chd_reg[6], chd_reg[7]};
    wire any_param = chd_reg[0][0] | chd_reg[1][0] | chd_reg[2][0] | chd_reg[3][0] |
                     chd_reg[4][0] | chd_reg[5][0] | chd_reg[6][0] | chd_reg[7][0];
    wire diag_any = any_chan | supply_err_reg | lost_reg;
    wire [31:0] diag0 = {1'b0, lost_reg, 6'h00, 8'h00, `DREC_BYTE1,
                         any_param, 2'b00, supply_err_reg, any_chan, supply_err_reg, 1'b0, diag_any};
    wire [7:0] chan_err = {|chd_reg[7], |chd_reg[6], |chd_reg[5], |chd_reg[4],
                           |chd_reg[3], |chd_reg[2], |chd_reg[1], |chd_reg[0]};

    // ********************************************
    // sticky status, outputs
    // ********************************************
    wire [2:0] ev = {busy_reg && |(rise & again), diag_any, |fresh};
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= 3'h0;
            limit_irq_reg <= 1'b0;
            diag_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= (wr && is_addr(addr, `OFF_IRQ_STAT) ? stat_reg & ~wdata[2:0] : stat_reg) | ev;
            limit_irq_reg <= busy_reg;
            diag_irq_reg <= diag_any && ctrl_reg[`CTRL_DIAG_EN];
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    // ********************************************
    // read port, data one cycle after rd
    // ********************************************
    always @* begin
        case (addr)
            `OFF_CTRL: rd_mux_reg = ctrl_reg;
            `OFF_HI_LIM0: rd_mux_reg = {16'h0000, hi0_reg};
            `OFF_LO_LIM0: rd_mux_reg = {16'h0000, lo0_reg};
            `OFF_HI_LIM2: rd_mux_reg = {16'h0000, hi2_reg};
            `OFF_LO_LIM2: rd_mux_reg = {16'h0000, lo2_reg};
            `OFF_INFO: rd_mux_reg = info_reg;
            `OFF_DIAG0: rd_mux_reg = diag0;
            `OFF_CHAN_DIAG: rd_mux_reg = {24'h000000, chan_err};
            `OFF_IRQ_STAT: rd_mux_reg = {29'h00000000, stat_reg};
            `OFF_IRQ_MASK: rd_mux_reg = {29'h00000000, mask_reg};
            default: rd_mux_reg = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) rd_val_reg <= 1'b0;
        else rd_val_reg <= rd && (addr[7:5] == 3'b010);
    end

    // value window reads do not come from the memory; they hit the default case and return zero
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) rdata_reg <= 32'h0000_0000;
        else if (rd) rdata_reg <= rd_mux_reg;
        else rdata_reg <= 32'h0000_0000;
    end
endmodule // aio_event_top
`default_nettype wire

// file: sim/aio_event_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "aio_event_defs.vh"
// ****************************************
// port checker for the event block
// ****************************************
module aio_event_checker (
    input wire logic core_clk, // clock
    input wire logic nrst, // async reset, active low
    input wire logic [7:0] addr, // register address
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata_reg, // read data
    input wire logic limit_irq_reg, // limit request
    input wire logic diag_irq_reg, // diagnostic request
    input wire logic irq_reg // summary request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [3:0] ctrl_reg;
    logic mask_nz_reg;
    logic en_seen_reg;
    // shadows of what software wrote, so the gates can be judged from outside
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= 4'h0;
            mask_nz_reg <= 1'b0;
            en_seen_reg <= 1'b0;
        end else if (wr && addr == `OFF_CTRL) begin
            ctrl_reg <= wdata[3:0];
            en_seen_reg <= en_seen_reg | (wdata[1:0] != 2'h0);
        end else if (wr && addr == `OFF_IRQ_MASK) begin
            mask_nz_reg <= (wdata[2:0] != 3'h0);
        end
    end
    chk_rdata_idle: assert property (!$past(rd) |-> rdata_reg == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_ctrl_readback: assert property ($past(rd && addr == `OFF_CTRL) |-> rdata_reg[3:0] == ctrl_reg)
        else $error("control readback differs from last write");
    chk_irq_mask: assert property (irq_reg |-> mask_nz_reg || $past(mask_nz_reg))
        else $error("summary interrupt while fully masked");
    chk_limit_off: assert property (limit_irq_reg |-> en_seen_reg)
        else $error("limit request before any enable");
    chk_limit_gate: assert property ($rose(limit_irq_reg) |->
        (ctrl_reg[1:0] | $past(ctrl_reg[1:0]) | $past(ctrl_reg[1:0], 2) | $past(ctrl_reg[1:0], 3)) != 2'h0)
        else $error("limit request rose while disabled");
    chk_diag_gate: assert property (diag_irq_reg |-> ctrl_reg[2] || $past(ctrl_reg[2]))
        else $error("diagnostic request while not enabled");
    chk_ack_clears: assert property (wr && addr == `OFF_ACK && !$past(wr && addr == `OFF_IRQ_MASK)
        |-> ##2 !limit_irq_reg)
        else $error("limit request survived acknowledge");
    chk_limit_hold: assert property ($fell(limit_irq_reg) |-> $past(wr, 2) && $past(addr, 2) == `OFF_ACK)
        else $error("limit request dropped without acknowledge");
endmodule // aio_event_checker
bind aio_event_top aio_event_checker aio_event_checker_inst (.core_clk, .nrst, .addr, .wdata, .wr, .rd,
    .rdata_reg, .limit_irq_reg, .diag_irq_reg, .irq_reg);
`default_nettype wire

// file: sim/conv_source.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// converter front end model
// ****************************************
module conv_source (
    input wire logic core_clk, // clock
    input wire logic go, // request from the bench
    input wire logic [2:0] chan_in, // channel to convert
    input wire logic [15:0] val_in, // value to deliver
    output var logic conv_valid = 1'b0, // one-cycle pulse
    output var logic [2:0] conv_chan = 3'h0, // channel
    output var logic [15:0] conv_value = 16'h0 // value
);
    // data bus toggles between pulses so sampling without the pulse shows
    always @(posedge core_clk) begin
        conv_valid <= go;
        conv_chan <= go ? chan_in : ~conv_chan;
        conv_value <= go ? val_in : ~conv_value;
    end
endmodule // conv_source
`default_nettype wire

// file: sim/test_aio_event_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aio_event_defs.vh"
// ****************************************
// bench for the event block
// ****************************************
module test_aio_event_top;
    logic core_clk, nrst, wr, rd, cur_4_20, gnd_open, ext_supply_ok, param_wr, go;
    logic [7:0] addr, param_fcode;
    logic [31:0] wdata, d;
    logic [15:0] loop_ua, gnd_diff_mv, cval;
    logic [2:0] param_chan, cchan;
    wire logic conv_valid, limit_irq_reg, diag_irq_reg, irq_reg;
    wire logic [2:0] conv_chan;
    wire logic [15:0] conv_value;
    wire logic [31:0] rdata_reg;
    int n_fail, n_checks;
    logic [2:0] tch [0:5] = '{3'h0, 3'h2, 3'h0, 3'h2, 3'h1, 3'h0};
    logic [15:0] tval [0:5] = '{16'h0096, 16'h00FA, 16'hFF6A, 16'hFF06, 16'h7530, 16'h0064};
    logic [31:0] texp [0:5] = '{32'h1, 32'h2, 32'h100, 32'h200, 32'h0, 32'h0};
    aio_event_top aio_event_top_inst (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_reg(rdata_reg), .conv_valid(conv_valid), .conv_chan(conv_chan),
        .conv_value(conv_value), .loop_ua(loop_ua), .cur_4_20(cur_4_20), .gnd_diff_mv(gnd_diff_mv),
        .gnd_open(gnd_open), .ext_supply_ok(ext_supply_ok), .param_wr(param_wr), .param_chan(param_chan),
        .param_fcode(param_fcode), .limit_irq_reg(limit_irq_reg), .diag_irq_reg(diag_irq_reg), .irq_reg(irq_reg));
    conv_source conv_source_inst (.core_clk(core_clk), .go(go), .chan_in(cchan), .val_in(cval),
        .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_value(conv_value));
    // 50 ns clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe, so sample just past the edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 v = rdata_reg;
    endtask
    task automatic conv(input logic [2:0] c, input logic [15:0] v);
        @(posedge core_clk);
        go <= 1'b1;
        cchan <= c;
        cval <= v;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test;
    end
    initial begin
        {nrst, wr, rd, cur_4_20, gnd_open, param_wr, go} = 7'h0;
        {addr, param_fcode, param_chan, cchan} = 22'h0;
        {wdata, cval, gnd_diff_mv} = 64'h0;
        loop_ua = 16'h2710;
        ext_supply_ok = 1'b1;
        n_fail = 0;
        n_checks = 0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        check({29'h0, limit_irq_reg, diag_irq_reg, irq_reg}, 32'h0);
        rd_reg(`OFF_CTRL, d);
        check(d, 32'h0);
        wr_reg(`OFF_HI_LIM0, 32'h0000_0064);
        wr_reg(`OFF_LO_LIM0, 32'h0000_FF9C);
        wr_reg(`OFF_HI_LIM2, 32'h0000_00C8);
        wr_reg(`OFF_LO_LIM2, 32'h0000_FF38);
        conv(3'h0, 16'h0096);
        rd_reg(`OFF_INFO, d);
        check(d, 32'h0);
        check({31'h0, limit_irq_reg}, 32'h0);
        $display("test disabled limits done");
        conv(3'h0, 16'h0000);
        wr_reg(`OFF_CTRL, 32'h0000_0003);
        // each entry crosses one limit edge or none; strict compare at equality
        for (int i = 0; i < 6; i++) begin
            conv(tch[i], tval[i]);
            rd_reg(`OFF_INFO, d);
            check(d, texp[i]);
            check({31'h0, limit_irq_reg}, {31'h0, texp[i] != 32'h0});
            wr_reg(`OFF_ACK, 32'h0000_0001);
            repeat (2) @(posedge core_clk);
            check({31'h0, limit_irq_reg}, 32'h0);
            wr_reg(`OFF_IRQ_STAT, 32'h0000_0007);
        end
        $display("test limit table done");
        wr_reg(`OFF_IRQ_MASK, 32'h0000_0001);
        conv(3'h0, 16'h0096);
        check({31'h0, irq_reg}, 32'h1);
        rd_reg(`OFF_IRQ_STAT, d);
        check({31'h0, d[`IRQ_LIMIT]}, 32'h1);
        conv(3'h0, 16'h0000);
        conv(3'h0, 16'h0096);
        check({31'h0, limit_irq_reg}, 32'h1);
        rd_reg(`OFF_DIAG0, d);
        check({31'h0, d[`DREC_LOST_BIT]}, 32'h1);
        rd_reg(`OFF_IRQ_STAT, d);
        check({31'h0, d[`IRQ_LOST]}, 32'h1);
        wr_reg(`OFF_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq_reg}, 32'h0);
        wr_reg(`OFF_ACK, 32'h0000_0001);
        wr_reg(`OFF_IRQ_STAT, 32'h0000_0007);
        rd_reg(`OFF_IRQ_STAT, d);
        check({31'h0, d[`IRQ_LIMIT]}, 32'h0);
        $display("test lost interrupt done");
        ext_supply_ok <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd_reg(`OFF_DIAG0, d);
        check({31'h0, d[`DREC_SUPPLY_BIT]}, 32'h1);
        check({31'h0, diag_irq_reg}, 32'h0);
        wr_reg(`OFF_CTRL, 32'h0000_0007);
        repeat (2) @(posedge core_clk);
        check({31'h0, diag_irq_reg}, 32'h1);
        ext_supply_ok <= 1'b1;
        @(posedge core_clk);
        param_wr <= 1'b1;
        param_chan <= 3'h1;
        param_fcode <= 8'h20;
        @(posedge core_clk);
        param_wr <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd_reg(`OFF_DIAG0, d);
        check({31'h0, d[`DREC_PARAM_BIT]}, 32'h1);
        conv(3'h3, 16'h7F00);
        rd_reg(`OFF_DIAG0, d);
        check({31'h0, d[`DREC_CHAN_BIT]}, 32'h1);
        cur_4_20 <= 1'b1;
        loop_ua <= 16'h0E0F;
        wr_reg(`OFF_CTRL, 32'h0000_000F);
        conv(3'h4, 16'h0000);
        cur_4_20 <= 1'b0;
        gnd_open <= 1'b1;
        conv(3'h5, 16'h0000);
        gnd_open <= 1'b0;
        conv(3'h6, 16'h8000);
        rd_reg(`OFF_CHAN_DIAG, d);
        check(d, 32'h0000_007A);
        $display("test diagnostics done");
        finish_test;
    end
endmodule // test_aio_event_top
`default_nettype wire
